// [hdl/frcfg_regs.sv]
// Purpose: Register bank for fault record status and chip bus config
// Assumes: Byte-wide register port synchronous to ref_clk
// Notes:   Read data is registered, one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module frcfg_regs (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        dual_input5_logic_level,
   input  wire logic        dual_input5_limit_flag,
   input  wire logic        dual_input4_limit_flag,
   input  wire logic        dual_input3_limit_flag,
   input  wire logic        record_stored,
   input  wire logic        bus_fault,
   input  wire logic        sequence_fault,
   output logic      [3:0]  chip_bus_node_address,
   output logic             chip_bus_addr_valid,
   output logic             seq_jump,
   output logic      [5:0]  seq_jump_state,
   output logic             record_area_full
);
   typedef struct packed {
      logic [7:0] rdata;
      logic       rvalid;
      logic [3:0] node_addr;
      logic       addr_valid;
      logic       jump;
      logic [5:0] jump_state;
      logic       full;
   } frcfg_state_t;

   frcfg_state_t s_q;
   frcfg_state_t s_d;

   logic [frcfg_pkg::ADDR_W-1:0]  addr_field;
   logic [frcfg_pkg::STATE_W-1:0] bus_target;
   logic [frcfg_pkg::STATE_W-1:0] seq_target;
   logic [7:0]                    ptr;
   logic                          ptr_full;
   logic                          wr_addr;
   logic                          wr_bus;
   logic                          wr_seq;

   // Only the three config offsets accept writes
   always_comb begin
      wr_addr = 1'b0;
      wr_bus  = 1'b0;
      wr_seq  = 1'b0;
      if (reg_wr && reg_addr == frcfg_pkg::OFF_CHIP_ADDR) begin
         wr_addr = 1'b1;
      end else if (reg_wr && reg_addr == frcfg_pkg::OFF_BUS_FAULT) begin
         wr_bus = 1'b1;
      end else if (reg_wr && reg_addr == frcfg_pkg::OFF_SEQ_FAULT) begin
         wr_seq = 1'b1;
      end
   end

   // Address comes from the register only, never the pin straps
   frcfg_cfg_field #(
      .W   (frcfg_pkg::ADDR_W),
      .RST (frcfg_pkg::ADDR_RESET)
   ) u_addr (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .wr_en   (wr_addr),
      .wr_data (reg_wdata[frcfg_pkg::ADDR_W-1:0]),
      .field_q (addr_field)
   );

   frcfg_cfg_field #(
      .W   (frcfg_pkg::STATE_W),
      .RST (frcfg_pkg::TARGET_RESET)
   ) u_bus (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .wr_en   (wr_bus),
      .wr_data (reg_wdata[frcfg_pkg::STATE_W-1:0]),
      .field_q (bus_target)
   );

   frcfg_cfg_field #(
      .W   (frcfg_pkg::STATE_W),
      .RST (frcfg_pkg::TARGET_RESET)
   ) u_seq (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .wr_en   (wr_seq),
      .wr_data (reg_wdata[frcfg_pkg::STATE_W-1:0]),
      .field_q (seq_target)
   );

   frcfg_record_ptr u_ptr (
      .ref_clk       (ref_clk),
      .rst_n         (rst_n),
      .clk_en        (clk_en),
      .record_stored (record_stored),
      .ptr_q         (ptr),
      .full_q        (ptr_full)
   );

   always_comb begin
      s_d        = s_q;
      s_d.rvalid = 1'b0;
      s_d.jump   = 1'b0;
      if (reg_rd) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = 8'h00;
         if (reg_addr == frcfg_pkg::OFF_CHIP_ADDR) begin
            s_d.rdata = {4'h0, addr_field};
         end else if (reg_addr == frcfg_pkg::OFF_BUS_FAULT) begin
            s_d.rdata = {2'b00, bus_target};
         end else if (reg_addr == frcfg_pkg::OFF_SEQ_FAULT) begin
            s_d.rdata = {2'b00, seq_target};
         end else if (reg_addr == frcfg_pkg::OFF_GPI_STAT) begin
            s_d.rdata = {7'h00, dual_input5_logic_level};
         end else if (reg_addr == frcfg_pkg::OFF_LIM_STAT5) begin
            s_d.rdata = {5'h00, dual_input5_limit_flag,
                         dual_input4_limit_flag,
                         dual_input3_limit_flag};
         end else if (reg_addr == frcfg_pkg::OFF_NEXT_PTR) begin
            s_d.rdata = ptr;
         end else if (reg_addr == frcfg_pkg::OFF_REVISION) begin
            s_d.rdata = {frcfg_pkg::FAMILY_CODE,
                         frcfg_pkg::HW_REVISION};
         end
      end
      s_d.node_addr = addr_field;
      // Broadcast value or out-of-range never claims a node slot
      s_d.addr_valid = (addr_field != frcfg_pkg::ADDR_BROADCAST)
                    && (addr_field <= 4'h4);
      // Bus fault wins when both arrive together
      if (bus_fault) begin
         s_d.jump       = 1'b1;
         s_d.jump_state = bus_target;
      end else if (sequence_fault) begin
         s_d.jump       = 1'b1;
         s_d.jump_state = seq_target;
      end
      s_d.full = ptr_full;
      if (!clk_en) begin
         s_d = s_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata             = s_q.rdata;
   assign reg_rvalid            = s_q.rvalid;
   assign chip_bus_node_address = s_q.node_addr;
   assign chip_bus_addr_valid   = s_q.addr_valid;
   assign seq_jump              = s_q.jump;
   assign seq_jump_state        = s_q.jump_state;
   assign record_area_full      = s_q.full;
endmodule
`default_nettype wire

// [inc/frcfg_pkg.sv]
// Purpose: Constants for the fault record and chip bus config bank
// Assumes: 8-bit register offsets on the management register port
// Notes:   Values here are shared by design and bench
`default_nettype none
package frcfg_pkg;
   localparam logic [7:0] OFF_CHIP_ADDR   = 8'h56;
   localparam logic [7:0] OFF_BUS_FAULT   = 8'h57;
   localparam logic [7:0] OFF_SEQ_FAULT   = 8'h5e;
   localparam logic [7:0] OFF_LIM_STAT5   = 8'hf0;
   localparam logic [7:0] OFF_NEXT_PTR    = 8'hf1;
   localparam logic [7:0] OFF_REVISION    = 8'hf5;
   localparam logic [7:0] OFF_GPI_STAT    = 8'he8;
   localparam logic [7:0] PTR_EMPTY       = 8'h80;
   localparam logic [7:0] PTR_LAST        = 8'hf8;
   localparam logic [7:0] PTR_FULL        = 8'h00;
   localparam logic [7:0] PTR_STEP        = 8'h08;
   localparam logic [3:0] ADDR_RESET      = 4'h1;
   localparam logic [3:0] ADDR_BROADCAST  = 4'h0;
   localparam logic [5:0] TARGET_RESET    = 6'h00;
   // Arbitrary neutral identity values
   localparam logic [3:0] FAMILY_CODE     = 4'h5;
   localparam logic [3:0] HW_REVISION     = 4'h1;
   localparam int         ADDR_W          = 4;
   localparam int         STATE_W         = 6;
endpackage
`default_nettype wire

// [hdl/frcfg_cfg_field.sv]
// Purpose: One read/write config field with reset value
// Assumes: Write strobe synchronous to ref_clk
// Notes:   Upper byte bits are reserved and not stored
`timescale 1ns/1ps
`default_nettype none
module frcfg_cfg_field #(
   parameter int              W   = 4,
   parameter logic [W-1:0]    RST = '0
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          clk_en,
   input  wire logic          wr_en,
   input  wire logic [W-1:0]  wr_data,
   output logic      [W-1:0]  field_q
);
   typedef struct packed {
      logic [W-1:0] val;
   } frcfg_field_t;
   frcfg_field_t s_q;
   frcfg_field_t s_d;
   always_comb begin
      s_d = s_q;
      if (clk_en && wr_en) begin
         s_d.val = wr_data;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.val <= RST;
      end else begin
         s_q <= s_d;
      end
   end
   assign field_q = s_q.val;
endmodule
`default_nettype wire

// [hdl/frcfg_record_ptr.sv]
// Purpose: Next free fault record slot pointer
// Assumes: One store strobe per record written
// Notes:   Saturates when the record area is full
`timescale 1ns/1ps
`default_nettype none
module frcfg_record_ptr (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic        record_stored,
   output logic      [7:0]  ptr_q,
   output logic             full_q
);
   typedef struct packed {
      logic [7:0] ptr;
      logic       full;
   } frcfg_ptr_t;
   frcfg_ptr_t s_q;
   frcfg_ptr_t s_d;
   always_comb begin
      s_d = s_q;
      if (clk_en && record_stored && !s_q.full) begin
         if (s_q.ptr == frcfg_pkg::PTR_LAST) begin
            s_d.ptr  = frcfg_pkg::PTR_FULL;
            s_d.full = 1'b1;
         end else begin
            s_d.ptr = s_q.ptr + frcfg_pkg::PTR_STEP;
         end
      end
   end
   // Full holds the pointer; no wrap back to the empty value
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q.ptr  <= frcfg_pkg::PTR_EMPTY;
         s_q.full <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end
   assign ptr_q  = s_q.ptr;
   assign full_q = s_q.full;
endmodule
`default_nettype wire

// [tb/frcfg_properties.sv]
// Purpose: Port assertions for the register bank
// Assumes: clk_en held high
// Notes:   Bound to frcfg_regs
`timescale 1ns/1ps
`default_nettype none
module frcfg_properties (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic       clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   input wire logic       bus_fault,
   input wire logic       sequence_fault,
   input wire logic [3:0] chip_bus_node_address,
   input wire logic       chip_bus_addr_valid,
   input wire logic       seq_jump,
   input wire logic       record_area_full
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic rd_go;
   logic flt;
   assign rd_go = reg_rd && clk_en;
   assign flt   = (bus_fault || sequence_fault) && clk_en;
   rd_answer_a: assert property (rd_go |=> reg_rvalid)
      else $error("read not answered");
   no_answer_a: assert property (!rd_go |=> !reg_rvalid)
      else $error("spurious read valid");
   jump_fault_a: assert property (flt |=> seq_jump)
      else $error("fault without jump");
   no_jump_a: assert property (!flt |=> !seq_jump)
      else $error("jump without fault");
   full_hold_a: assert property (record_area_full |=> record_area_full)
      else $error("full flag dropped");
   addr_valid_a: assert property (chip_bus_addr_valid ==
      (chip_bus_node_address inside {[4'h1:4'h4]})) else $error("bad valid");
   lim_rsvd_a: assert property (rd_go &&
      reg_addr == frcfg_pkg::OFF_LIM_STAT5 |=> reg_rdata[7:3] == 5'h00)
      else $error("reserved bits set");
   rev_read_a: assert property (rd_go &&
      reg_addr == frcfg_pkg::OFF_REVISION |=> reg_rdata ==
      {frcfg_pkg::FAMILY_CODE, frcfg_pkg::HW_REVISION})
      else $error("revision wrong");
   cover property (rd_go ##1 reg_rvalid);
   cover property (seq_jump);
   cover property ($rose(record_area_full));
endmodule
bind frcfg_regs frcfg_properties u_props (.ref_clk, .rst_n, .clk_en,
   .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid, .bus_fault, .sequence_fault,
   .chip_bus_node_address, .chip_bus_addr_valid, .seq_jump,
   .record_area_full);
`default_nettype wire

// [tb/frcfg_peer.sv]
// Purpose: Peer sequencer raising chip bus faults
// Assumes: Peer address differs from the device's
// Notes:   Pulses launch just after the rising edge
`timescale 1ns/1ps
`default_nettype none
module frcfg_peer #(
   parameter logic [3:0] PEER_ADDR = 4'h2
) (
   input  wire logic       ref_clk,
   input  wire logic [1:0] req,
   output logic            bus_fault,
   output logic            sequence_fault
);
   // Own address, unique and never broadcast
   logic [3:0] node_q = PEER_ADDR;
   // Coordination through fault pulses
   always_ff @(posedge ref_clk) begin
      bus_fault      <= req[0] && node_q != 4'h0;
      sequence_fault <= req[1];
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the register bank
// Assumes: Read answers one cycle after the strobe
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       ref_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       clk_en = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic       reg_rvalid;
   logic [3:0] lim = 4'h0;
   logic       record_stored = 1'b0;
   logic [1:0] req = 2'b00;
   logic       bus_fault;
   logic       sequence_fault;
   logic [3:0] node;
   logic       node_ok;
   logic       seq_jump;
   logic [5:0] jst;
   logic       full;
   int         fail_count = 0;
   int         n_checks = 0;
   frcfg_regs uut (.ref_clk, .rst_n, .clk_en, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
      .dual_input5_logic_level(lim[3]), .dual_input5_limit_flag(lim[2]),
      .dual_input4_limit_flag(lim[1]), .dual_input3_limit_flag(lim[0]),
      .record_stored, .bus_fault, .sequence_fault,
      .chip_bus_node_address(node), .chip_bus_addr_valid(node_ok),
      .seq_jump, .seq_jump_state(jst), .record_area_full(full));
   frcfg_peer peer (.ref_clk, .req, .bus_fault, .sequence_fault);
   initial forever #25 ref_clk = ~ref_clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid}, 8'h01);
      chk(reg_rdata, exp);
   endtask
   task automatic t_ro;
      wr(frcfg_pkg::OFF_REVISION, 8'h00);
      rd(frcfg_pkg::OFF_REVISION, 8'h51);
      wr(frcfg_pkg::OFF_NEXT_PTR, 8'h00);
      rd(frcfg_pkg::OFF_NEXT_PTR, 8'h80);
      wr(8'h60, 8'hff);
      rd(8'h60, 8'h00);
   endtask
   task automatic t_cfg;
      for (int v = 0; v < 6; v++) begin
         wr(frcfg_pkg::OFF_CHIP_ADDR, {4'hf, 4'(v)});
         rd(frcfg_pkg::OFF_CHIP_ADDR, {4'h0, 4'(v)});
         chk({3'h0, node_ok, node}, {3'h0, v inside {[1:4]}, 4'(v)});
      end
      wr(frcfg_pkg::OFF_BUS_FAULT, 8'hd5);
      rd(frcfg_pkg::OFF_BUS_FAULT, 8'h15);
      wr(frcfg_pkg::OFF_SEQ_FAULT, 8'hea);
      rd(frcfg_pkg::OFF_SEQ_FAULT, 8'h2a);
   endtask
   // Frozen bank takes neither writes nor reads
   task automatic t_freeze;
      @(negedge ref_clk);
      clk_en = 1'b0;
      wr(frcfg_pkg::OFF_CHIP_ADDR, 8'h03);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid}, 8'h00);
      clk_en = 1'b1;
      rd(frcfg_pkg::OFF_CHIP_ADDR, 8'h05);
   endtask
   task automatic t_stat;
      for (int i = 0; i < 16; i++) begin
         @(negedge ref_clk);
         lim = 4'(i);
         rd(frcfg_pkg::OFF_LIM_STAT5, {5'h00, lim[2:0]});
         rd(frcfg_pkg::OFF_GPI_STAT, {7'h00, lim[3]});
      end
   endtask
   task automatic fire(input logic [1:0] r, input logic [5:0] exp);
      @(negedge ref_clk);
      req = r;
      @(negedge ref_clk);
      req = 2'b00;
      @(negedge ref_clk);
      chk({1'b0, seq_jump, jst}, {2'b01, exp});
      @(negedge ref_clk);
      chk({7'h00, seq_jump}, 8'h00);
   endtask
   task automatic t_ptr;
      logic [7:0] e;
      for (int i = 1; i <= 17; i++) begin
         @(negedge ref_clk);
         record_stored = 1'b1;
         @(negedge ref_clk);
         record_stored = 1'b0;
         e = (i >= 16) ? 8'h00 : 8'h80 + 8'(i * 8);
         rd(frcfg_pkg::OFF_NEXT_PTR, e);
         chk({7'h00, full}, {7'h00, i >= 16});
      end
   endtask
   initial begin
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      t_ro;
      t_cfg;
      t_freeze;
      t_stat;
      fire(2'b01, 6'h15);
      fire(2'b10, 6'h2a);
      fire(2'b11, 6'h15);
      t_ptr;
      test_done;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      fail_count++;
      test_done;
   end
endmodule
`default_nettype wire
